// file: src/pwm_channel_pkg.sv
// package: register map, field layout and reset values of the pwm channel
package pwm_channel_pkg;
   // wishbone word offsets (byte addresses)
   localparam logic [3:0] CONTROL_OFFSET = 4'h0;
   localparam logic [3:0] DUTY_HIGH_OFFSET = 4'h4;
   localparam logic [3:0] DUTY_LOW_OFFSET = 4'h8;
   // control register fields
   localparam int ENABLE_BIT = 7;
   localparam int LEVEL_BIT = 5;
   localparam int POLARITY_BIT = 4;
   // duty low field position
   localparam int DUTY_LOW_MSB = 7;
   localparam int DUTY_LOW_LSB = 6;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [9:0] DUTY_POWER_ON = 10'h000;
   // reset kinds seen at the channel
   typedef enum logic [1:0] {
      RESET_NONE_ST = 2'b01,
      RESET_SOFT_ST = 2'b10
   } reset_kind_type;
endpackage

// file: src/duty_if.sv
// interface: duty value handed between register file and compare unit
`timescale 1ns/1ps
interface duty_if;
   logic [9:0] duty;
   logic enable;
   logic polarity;
   logic level;
   modport regs (output duty, output enable, output polarity, input level);
   modport cmp (input duty, input enable, input polarity, output level);
endinterface

// file: src/pwm_compare.sv
// compare unit: double-buffered duty against the 10-bit time base
`timescale 1ns/1ps
module pwm_compare
   import pwm_channel_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // timer side
   input wire logic [7:0] timer_count_i,
   input wire logic [1:0] prescale_phase_i,
   input wire logic period_match_i,
   input wire logic timer_cleared_i,
   // output
   output logic pwm_o,
   duty_if.cmp link
);
   logic [9:0] duty_buf_ff;
   logic raw_ff;
   logic [9:0] time_base;

   // time base: count extended by the two prescaled phase bits
   assign time_base = {timer_count_i, prescale_phase_i};

   // buffer loads only on the period match, next increment cycle
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         duty_buf_ff <= DUTY_POWER_ON;
      else if (ce_i && period_match_i)
         duty_buf_ff <= link.duty;
   end

   // raw waveform, active high before polarity
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         raw_ff <= 1'b0;
      else if (ce_i)
      begin
         if (!link.enable)
            raw_ff <= 1'b0;
         else if (timer_cleared_i)
            raw_ff <= (duty_buf_ff != 10'h000);
         else if (time_base == duty_buf_ff)
            raw_ff <= 1'b0;
      end
   end

   // polarity applied after the register so the level bit sees the pin value
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         pwm_o <= 1'b0;
      else if (ce_i)
         pwm_o <= raw_ff ^ link.polarity;
   end

   assign link.level = pwm_o;
endmodule

// file: src/ten_bit_pwm_channel.sv
// top: wishbone register file of one 10-bit pwm channel
`timescale 1ns/1ps
module ten_bit_pwm_channel
   import pwm_channel_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic soft_resetn_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // shared timer
   input wire logic [7:0] timer_count_i,
   input wire logic [1:0] prescale_phase_i,
   input wire logic period_match_i,
   input wire logic timer_cleared_i,
   // output
   output logic pwm_o
);
   duty_if link();
   // bus handshake states, one-hot so a stray code falls back to idle
   typedef enum logic [1:0] {
      BUS_IDLE_ST = 2'b01,
      BUS_ACK_ST = 2'b10
   } bus_state_type;
   bus_state_type bus_state_ff;
   bus_state_type nxt_bus_state;
   logic enable_ff;
   logic polarity_ff;
   logic [7:0] duty_high_ff;
   logic [1:0] duty_low_ff;
   logic [31:0] dat_ff;
   logic wr_req;
   logic rd_req;
   logic [31:0] nxt_dat;
   logic sel_control;
   logic sel_duty_high;
   logic sel_duty_low;
   logic bus_taken;
   logic wr_control;
   logic wr_duty_high;
   logic wr_duty_low;

   // register map, one byte of each 32-bit word is used:
   //   control    bit 7 enable, bit 5 live output level (read only), bit 4 polarity
   //   duty high  duty bits 9..2
   //   duty low   duty bits 1..0 in bits 7..6
   // every other bit, lane or offset reads zero and drops writes

   // limitations:
   //   only the low byte lane is decoded; sel_i[3:1] are ignored
   //   a soft reset clears enable and polarity but never the duty pair,
   //   so the output stops until enable is written again, then resumes on the old buffered duty
   //   writes land on the edge that takes the request, the same edge that raises ack

   // offset match for the write selects; the read mux compares adr_i against the offsets in its own case
   function automatic logic addr_hit(input logic [3:0] adr, input logic [3:0] offset);
      addr_hit = (adr == offset);
   endfunction

   // register selects from the byte address, held by the master through ack
   assign sel_control = addr_hit(adr_i, CONTROL_OFFSET);
   assign sel_duty_high = addr_hit(adr_i, DUTY_HIGH_OFFSET);
   assign sel_duty_low = addr_hit(adr_i, DUTY_LOW_OFFSET);

   // a request is taken only in idle; in the ack cycle the master still holds
   // stb, and taking it again there would write twice or shift the read data
   assign bus_taken = cyc_i && stb_i && ce_i && (bus_state_ff == BUS_IDLE_ST);
   // writes need the low byte lane, the other lanes carry nothing we store
   assign wr_req = bus_taken && we_i && sel_i[0];
   assign rd_req = bus_taken && !we_i;

   // one write strobe per register
   assign wr_control = wr_req && sel_control;
   assign wr_duty_high = wr_req && sel_duty_high;
   assign wr_duty_low = wr_req && sel_duty_low;

   // idle -> ack on a request, ack -> idle always: ack is a one-cycle pulse,
   // a held stb sees ack fall in the next cycle and is taken again as a new
   // request in that idle cycle, with no stb low cycle needed in between
   always_comb
   begin
      nxt_bus_state = bus_state_ff;
      case (bus_state_ff)
         BUS_IDLE_ST:
            if (cyc_i && stb_i)
               nxt_bus_state = BUS_ACK_ST;
         BUS_ACK_ST:
            nxt_bus_state = BUS_IDLE_ST;
         default:
            nxt_bus_state = BUS_IDLE_ST;
      endcase
   end

   // state register, frozen with everything else while ce_i is low
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         bus_state_ff <= BUS_IDLE_ST;
      else if (ce_i)
         bus_state_ff <= nxt_bus_state;
   end
   assign ack_o = (bus_state_ff == BUS_ACK_ST);

   // enable bit: a soft reset clears it like a power-on reset
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         enable_ff <= CONTROL_RESET[ENABLE_BIT];
      else if (ce_i)
      begin
         if (!soft_resetn_i)
            enable_ff <= CONTROL_RESET[ENABLE_BIT];
         else if (wr_control)
            enable_ff <= dat_i[ENABLE_BIT];
      end
   end

   // polarity bit: reaches the pin one edge after it changes, since the
   // compare unit applies it behind its raw waveform register
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         polarity_ff <= CONTROL_RESET[POLARITY_BIT];
      else if (ce_i)
      begin
         if (!soft_resetn_i)
            polarity_ff <= CONTROL_RESET[POLARITY_BIT];
         else if (wr_control)
            polarity_ff <= dat_i[POLARITY_BIT];
      end
   end

   // duty high byte: only the power-on reset touches it, a soft reset keeps it
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         duty_high_ff <= DUTY_POWER_ON[9:2];
      else if (wr_duty_high)
         duty_high_ff <= dat_i[7:0];
   end

   // duty low pair: same reset rule; bits 5..0 are not stored at all
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         duty_low_ff <= DUTY_POWER_ON[1:0];
      else if (wr_duty_low)
         duty_low_ff <= dat_i[DUTY_LOW_MSB:DUTY_LOW_LSB];
   end

   // read mux, unmapped offsets read zero; the level bit is the pin itself,
   // so software sees the waveform after polarity, not the raw compare state
   always_comb
   begin
      nxt_dat = 32'h0000_0000;
      case (adr_i)
         CONTROL_OFFSET:
         begin
            nxt_dat[ENABLE_BIT] = enable_ff;
            nxt_dat[LEVEL_BIT] = link.level;
            nxt_dat[POLARITY_BIT] = polarity_ff;
         end
         DUTY_HIGH_OFFSET: nxt_dat[7:0] = duty_high_ff;
         DUTY_LOW_OFFSET: nxt_dat[DUTY_LOW_MSB:DUTY_LOW_LSB] = duty_low_ff;
         default: nxt_dat = 32'h0000_0000;
      endcase
   end

   // read data register, loaded only when a read is taken so it stands
   // unchanged through the ack cycle even though the level bit moves on
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         dat_ff <= 32'h0000_0000;
      else if (rd_req)
         dat_ff <= nxt_dat;
   end
   assign dat_o = dat_ff;

   // duty pair and control bits handed to the compare unit; the duty is the
   // live register value, the compare unit keeps its own buffered copy
   assign link.duty = {duty_high_ff, duty_low_ff};
   assign link.enable = enable_ff;
   assign link.polarity = polarity_ff;

   // compare unit timing, all inputs on this clock:
   //   period_match_i  buffer loads the duty pair at this edge
   //   timer_cleared_i output goes active unless the buffered duty is zero
   //   time base equal to the buffered duty drops the output again
   // a duty at or above the period never matches, so the output stays active
   pwm_compare i_pwm_compare (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .timer_count_i(timer_count_i),
      .prescale_phase_i(prescale_phase_i),
      .period_match_i(period_match_i),
      .timer_cleared_i(timer_cleared_i),
      .pwm_o(pwm_o),
      .link(link)
   );
endmodule

// file: test/pwm_timer_model.sv
// shared period timer model: count, phase, match and clear pulses
`timescale 1ns/1ps
module pwm_timer_model #(parameter logic [7:0] PERIOD = 8'h03)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // timer outputs
   output logic [7:0] count_o,
   output logic [1:0] phase_o,
   output logic match_o,
   output logic cleared_o
);
   // count steps once per four phases, wraps after the period match
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         count_o <= 8'h00;
         phase_o <= 2'h0;
      end
      else
      begin
         phase_o <= phase_o + 2'h1;
         if (phase_o == 2'h3)
            count_o <= (count_o == PERIOD) ? 8'h00 : count_o + 8'h01;
      end
   end
   // single-cycle events, as the real timer gives them
   assign match_o = (count_o == PERIOD) && (phase_o == 2'h3);
   assign cleared_o = (count_o == 8'h00) && (phase_o == 2'h0);
endmodule

// file: test/ten_bit_pwm_channel_checker.sv
// checker: bus handshake and output rules at the channel ports
`timescale 1ns/1ps
module ten_bit_pwm_channel_checker
   import pwm_channel_pkg::*;
(
   // clock and resets
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic soft_resetn_i,
   input wire logic ce_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // output
   input wire logic pwm_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o) else $error("no ack");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
   wide_zero_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("upper bits");
   ctrl_zero_a: assert property (ack_o && !we_i && adr_i == CONTROL_OFFSET |-> dat_o[3:0] == 4'h0 && !dat_o[6])
      else $error("control unused bits");
   low_zero_a: assert property (ack_o && !we_i && adr_i == DUTY_LOW_OFFSET |-> dat_o[5:0] == 6'h0)
      else $error("duty low unused bits");
   freeze_a: assert property (!ce_i |=> $stable(pwm_o) && $stable(ack_o)) else $error("moved while frozen");
   soft_idle_a: assert property (!soft_resetn_i && ce_i ##1 (ce_i && !stb_i)[*3] |-> !pwm_o)
      else $error("output active after soft reset");
   cover property (ack_o && we_i);
   cover property (ack_o && !we_i);
   cover property (!soft_resetn_i);
endmodule
bind ten_bit_pwm_channel ten_bit_pwm_channel_checker i_ten_bit_pwm_channel_checker (.*);

// file: test/test_ten_bit_pwm_channel.sv
// testbench: register access and waveform checks of one pwm channel
`timescale 1ns/1ps
module test_ten_bit_pwm_channel
   import pwm_channel_pkg::*;
;
   logic clk_i, resetn_i, soft_resetn_i, ce_i, cyc_i, stb_i, we_i, ack_o, pwm_o;
   logic [3:0] adr_i, sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [7:0] timer_count_i;
   logic [1:0] prescale_phase_i;
   logic period_match_i, timer_cleared_i;
   int err_count, checked;
   ten_bit_pwm_channel i_ten_bit_pwm_channel (.*);
   pwm_timer_model i_pwm_timer_model (.clk_i(clk_i), .resetn_i(resetn_i), .count_o(timer_count_i),
      .phase_o(prescale_phase_i), .match_o(period_match_i), .cleared_o(timer_cleared_i));
   task stop_test;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // one classic cycle; a missing ack ends the run
   task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      logic got;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
         got = (ack_o === 1'b1);
      end
      while (!got && n < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
      if (!got)
      begin
         err_count++;
         stop_test();
      end
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk("register", {24'h0, e}, q);
   endtask
   // high cycles over one 16-cycle period after the buffers settle
   task run(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l, input logic [4:0] e);
      logic [4:0] hi;
      wb(1'b1, DUTY_HIGH_OFFSET, h);
      wb(1'b1, DUTY_LOW_OFFSET, l);
      wb(1'b1, CONTROL_OFFSET, c);
      repeat (40) @(posedge clk_i);
      hi = 5'h00;
      repeat (16)
      begin
         @(posedge clk_i);
         hi += {4'h0, pwm_o};
      end
      chk("high cycles", {27'h0, e}, {27'h0, hi});
      $display("pwm run done");
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      {resetn_i, cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      {soft_resetn_i, ce_i, sel_i} = 6'h3F;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      rd(CONTROL_OFFSET, CONTROL_RESET);
      rd(DUTY_HIGH_OFFSET, DUTY_POWER_ON[9:2]);
      wb(1'b1, DUTY_HIGH_OFFSET, 8'hFF);
      rd(DUTY_HIGH_OFFSET, 8'hFF);
      sel_i <= 4'hE;
      wb(1'b1, DUTY_HIGH_OFFSET, 8'h55);
      sel_i <= 4'hF;
      rd(DUTY_HIGH_OFFSET, 8'hFF);
      wb(1'b1, DUTY_LOW_OFFSET, 8'hFF);
      rd(DUTY_LOW_OFFSET, 8'hC0);
      wb(1'b1, CONTROL_OFFSET, 8'h1F);
      rd(CONTROL_OFFSET, 8'h30);
      wb(1'b1, 4'hC, 8'hFF);
      rd(4'hC, 8'h00);
      $display("register test done");
      run(8'h80, 8'h01, 8'h40, 5'h05);
      run(8'h90, 8'h01, 8'h40, 5'h0B);
      run(8'h80, 8'hFF, 8'hC0, 5'h10);
      run(8'h80, 8'h00, 8'h00, 5'h00);
      run(8'h10, 8'h01, 8'h40, 5'h10);
      ce_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      soft_resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      soft_resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(CONTROL_OFFSET, 8'h00);
      rd(DUTY_HIGH_OFFSET, 8'h01);
      $display("soft reset test done");
      stop_test();
   end
endmodule
